// ==== verilog/clock_switch_reset_sequencer.sv ====
// Clock source switch, fast RC trim and reset sequencer with AHB-Lite registers.
// Assumes oscillator clocks and reset sources arrive asynchronously on pins.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module clock_switch_reset_sequencer
  import clk_rst_pkg::*;
#(
  parameter int LONG_DELAY  = DELAY_LONG,
  parameter int SHORT_DELAY = DELAY_SHORT,
  parameter logic [7:0] FT_HI0 = 8'h80,  // Arbitrary factory trim default
  parameter logic [7:0] FT_LO0 = 8'h00,
  parameter logic [7:0] FT_HI1 = 8'h80,
  parameter logic [7:0] FT_LO1 = 8'h00
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  startup_clock_option,
  input  wire logic        in_circuit_comms,
  input  wire logic        halt_wakeup_entry,
  input  wire logic        fast_rc_clk,
  input  wire logic        slow_rc_clk,
  input  wire logic        ext_reset_in,
  input  wire logic        low_voltage_reset,
  input  wire logic        watchdog_reset,
  input  wire logic        illegal_opcode,
  output logic             reset_pin_out,
  output logic             reset_pin_oe,
  output logic             cpu_reset_n,
  output logic             vector_fetch,
  output logic [15:0]      vector_addr,
  output logic [9:0]       fast_rc_trim,
  output logic             fast_rc_enable,
  output logic             slow_rc_enable,
  output logic             xtal_enable,
  output logic             sys_clk_sel_slow,
  output logic             clock_gate_hold
);

  initial begin
    if (LONG_DELAY < 2 || SHORT_DELAY < 2 || LONG_DELAY > 65535 || SHORT_DELAY > LONG_DELAY)
      $error("Reset delay parameters out of range");
  end

  // Two-flop synchronisers for all asynchronous pins
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {slow_rc_clk, fast_rc_clk, ~ext_reset_in, low_voltage_reset,
                  watchdog_reset, illegal_opcode, in_circuit_comms};
      sync2_q <= sync1_q;
    end
  end
  logic slow_s, fast_s, ext_s, lvr_s, wdg_s, ill_s, icc_s;
  assign {slow_s, fast_s, ext_s, lvr_s, wdg_s, ill_s, icc_s} = sync2_q;

  // Oscillator edge detect on synchronised copies
  logic slow_d1_q;
  logic fast_d1_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_d1_q <= 1'b0;
      fast_d1_q <= 1'b0;
    end else begin
      slow_d1_q <= slow_s;
      fast_d1_q <= fast_s;
    end
  end
  logic slow_rise;
  logic fast_rise;
  assign slow_rise = slow_s & ~slow_d1_q;
  assign fast_rise = fast_s & ~fast_d1_q;

  // Reset sequencer state
  rs_state_t   rs_q;
  logic [15:0] dly_q;
  logic        fetch_q;
  logic        any_src;
  assign any_src = ext_s | lvr_s | wdg_s | ill_s;
  // Synchroniser depth; reset stays active until pin copies are valid
  localparam int SYNC_DEPTH = 2;

  // Trim registers
  logic [7:0] rc_trim_q;
  logic [1:0] trim_low_q;
  // Bus access phase capture
  logic       wr_pend_q;
  logic       rd_pend_q;
  logic [7:0] addr_q;
  logic       sel_q;
  logic       clr_flags;
  logic [3:0] rst_flags_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else if (hready) begin
      wr_pend_q <= hsel & htrans[1] & hwrite;
      rd_pend_q <= hsel & htrans[1] & ~hwrite;
      addr_q    <= haddr[7:0];
    end
  end
  assign sel_q = wr_pend_q && addr_q == CLK_CNT_OFF;
  assign clr_flags = wr_pend_q && addr_q == RESET_STAT_OFF;

  // trim written by software, reset to ff on every reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rc_trim_q  <= RC_TRIM_RST;
      trim_low_q <= 2'h0;
    end else if (rs_q != RS_FETCH || !cpu_reset_n) begin
      rc_trim_q  <= RC_TRIM_RST;
      trim_low_q <= 2'h0;
    end else if (wr_pend_q && addr_q == RC_TRIM_OFF) begin
      rc_trim_q <= hwdata[7:0];
    end else if (wr_pend_q && addr_q == SUPPLY_OFF) begin
      trim_low_q <= hwdata[SUP_TRIM_HI:SUP_TRIM_LO];
    end
  end

  // Select bit written by software
  logic sel_bit_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_bit_q <= 1'b0;
    end else if (rs_q == RS_ACTIVE) begin
      // startup choice seeds the select bit, else slow start falls back
      sel_bit_q <= (startup_clock_option == CKOPT_SLOW_RC) && !icc_s;
    end else if (sel_q) begin
      sel_bit_q <= hwdata[CK_SEL_BIT];
    end
  end

  // Clock switch machine
  sw_state_t  sw_q;
  logic [3:0] cnt_q;          // Counts slow RC edges, then fast RC edges, while settling
  logic       fast_flag_q;
  logic       slow_flag_q;
  logic       force_fast;
  assign force_fast = icc_s;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_q        <= SW_FAST;
      cnt_q       <= 4'h0;
      fast_flag_q <= 1'b1;
      slow_flag_q <= 1'b0;
    end else if (rs_q == RS_ACTIVE) begin
      // startup clock taken from option bits while in reset
      cnt_q <= 4'h0;
      if (force_fast || startup_clock_option == CKOPT_FAST_RC) begin
        sw_q        <= SW_FAST;
        fast_flag_q <= 1'b1;
        slow_flag_q <= 1'b0;
      end else if (startup_clock_option == CKOPT_SLOW_RC) begin
        sw_q        <= SW_SLOW;
        fast_flag_q <= 1'b0;
        slow_flag_q <= 1'b1;
      end else begin
        sw_q        <= SW_EXT;
        fast_flag_q <= 1'b0;
        slow_flag_q <= 1'b0;
      end
    end else begin
      unique case (sw_q)
        SW_FAST: begin
          // select bit starts move to slow RC
          if (sel_bit_q && !force_fast) begin
            sw_q        <= SW_TO_SLOW;
            fast_flag_q <= 1'b0;
            cnt_q       <= 4'h0;
          end
        end
        SW_TO_SLOW: begin
          // three slow cycles, then switch on rising edge
          if (slow_rise) begin
            if (cnt_q == 4'(SLOW_SETTLE_CYC - 1)) begin
              slow_flag_q <= 1'b1;
              sw_q        <= SW_SLOW;
              cnt_q       <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        SW_SLOW: begin
          if (!sel_bit_q || force_fast) begin
            sw_q  <= SW_WAIT_FAST;
            cnt_q <= 4'h0;
          end
        end
        SW_WAIT_FAST: begin
          // eight fast cycles on the four-bit counter
          if (fast_rise) begin
            if (cnt_q == 4'(FAST_SETTLE_CYC - 1)) begin
              cnt_q <= 4'h0;
              sw_q  <= SW_FLAG_FAST;
            end else begin
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        SW_FLAG_FAST: begin
          // slow flag drops on slow edge, fast flag after two fast
          if (slow_rise) begin
            slow_flag_q <= 1'b0;
          end
          if (fast_rise && cnt_q != 4'(FAST_FLAG_CYC)) begin
            cnt_q <= cnt_q + 4'h1;
          end
          if (!slow_flag_q && cnt_q == 4'(FAST_FLAG_CYC) && fast_rise) begin
            fast_flag_q <= 1'b1;
            sw_q        <= SW_FAST;
            cnt_q       <= 4'h0;
          end
        end
        SW_EXT: begin
          sw_q <= SW_EXT;
        end
        default: begin
          sw_q <= SW_FAST;
        end
      endcase
    end
  end

  // Oscillator enables and clock selection
  logic auto_wake_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fast_rc_enable   <= 1'b1;
      slow_rc_enable   <= 1'b0;
      xtal_enable      <= 1'b1;  // Crystal keeps running through reset
      sys_clk_sel_slow <= 1'b0;
      clock_gate_hold  <= 1'b0;
      auto_wake_q      <= 1'b0;
    end else begin
      auto_wake_q <= halt_wakeup_entry;
      // fast RC runs only when selected or being brought up
      fast_rc_enable <= (sw_q == SW_FAST) || (sw_q == SW_TO_SLOW)
                        || (sw_q == SW_WAIT_FAST) || (sw_q == SW_FLAG_FAST);
      // slow RC for switching, wakeup entry, or external clock
      slow_rc_enable <= (sw_q == SW_TO_SLOW) || (sw_q == SW_SLOW)
                        || (sw_q == SW_WAIT_FAST) || (sw_q == SW_FLAG_FAST)
                        || (sw_q == SW_EXT) || (sw_q == SW_FAST && auto_wake_q);
      // crystal not stopped in reset phase
      xtal_enable <= (startup_clock_option == CKOPT_XTAL);
      // Still on slow RC until the fast edge that completes the switch
      sys_clk_sel_slow <= (sw_q == SW_SLOW) || (sw_q == SW_WAIT_FAST)
                          || (sw_q == SW_FLAG_FAST);
      // clock output held at one during the change
      clock_gate_hold <= (sw_q == SW_TO_SLOW) || (sw_q == SW_FLAG_FAST);
    end
  end

  // Reset sequencer: active, delay, vector fetch
  logic [15:0] delay_len;
  assign delay_len = (startup_clock_option == CKOPT_SLOW_RC && !force_fast)
                     ? 16'(SHORT_DELAY) : 16'(LONG_DELAY);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rs_q    <= RS_ACTIVE;
      dly_q   <= 16'h0000;
      fetch_q <= 1'b0;
    end else begin
      unique case (rs_q)
        RS_ACTIVE: begin
          // count only after all sources released and pins settled
          if (any_src) begin
            dly_q <= 16'h0000;
          end else if (dly_q == 16'(SYNC_DEPTH)) begin
            rs_q  <= RS_DELAY;
            dly_q <= 16'h0000;
          end else begin
            dly_q <= dly_q + 16'h0001;
          end
        end
        RS_DELAY: begin
          if (any_src) begin
            rs_q  <= RS_ACTIVE;
            dly_q <= 16'h0000;
          end else if (dly_q == delay_len - 16'h0001) begin
            rs_q    <= RS_FETCH;
            fetch_q <= 1'b1;
            dly_q   <= 16'h0000;  // Even count so the fetch opens at the low byte
          end else begin
            dly_q <= dly_q + 16'h0001;
          end
        end
        RS_FETCH: begin
          if (any_src) begin
            rs_q    <= RS_ACTIVE;
            fetch_q <= 1'b0;
          end else if (fetch_q && dly_q == 16'(FETCH_CYC - 1)) begin
            fetch_q <= 1'b0;
          end else if (fetch_q) begin
            dly_q <= 16'(FETCH_CYC - 1);
          end
        end
        default: begin
          rs_q <= RS_ACTIVE;
        end
      endcase
    end
  end

  // Reset pin and CPU outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe  <= 1'b1;
      cpu_reset_n   <= 1'b0;
      vector_fetch  <= 1'b0;
      vector_addr   <= RESET_VECTOR_ADDR;
    end else begin
      reset_pin_out <= 1'b0;
      // pin driven low in active and delay phases
      reset_pin_oe  <= (rs_q != RS_FETCH) || any_src;
      cpu_reset_n   <= (rs_q == RS_FETCH) && !any_src;
      vector_fetch  <= (rs_q == RS_FETCH) && fetch_q && !any_src;
      vector_addr   <= RESET_VECTOR_ADDR | {15'h0000, (rs_q == RS_FETCH && dly_q[0])};
    end
  end

  // reset cause flags, low-voltage clears watchdog; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_flags_q <= 4'h0;
    end else begin
      rst_flags_q[RS_WDG_BIT] <= lvr_s ? 1'b0
        : (wdg_s | (rst_flags_q[RS_WDG_BIT] & ~(clr_flags & hwdata[RS_WDG_BIT])));
      rst_flags_q[RS_LVR_BIT] <= lvr_s
        | (rst_flags_q[RS_LVR_BIT] & ~(clr_flags & hwdata[RS_LVR_BIT]));
      rst_flags_q[RS_ILL_BIT] <= ill_s
        | (rst_flags_q[RS_ILL_BIT] & ~(clr_flags & hwdata[RS_ILL_BIT]));
      rst_flags_q[RS_EXT_BIT] <= ext_s
        | (rst_flags_q[RS_EXT_BIT] & ~(clr_flags & hwdata[RS_EXT_BIT]));
    end
  end

  // factory trim bytes, read-only; low bits sit at 6:5
  logic [31:0] factory_word;
  assign factory_word = {FT_LO1 & 8'h60, FT_HI1, FT_LO0 & 8'h60, FT_HI0};

  // Read mux, zero-wait answer; unmapped reads zero, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        RC_TRIM_OFF:      hrdata <= {24'h000000, rc_trim_q};
        SUPPLY_OFF:       hrdata <= {25'h0000000, trim_low_q, 5'h00};
        CLK_CNT_OFF:      hrdata <= {29'h00000000, slow_flag_q, fast_flag_q, sel_bit_q};
        RESET_STAT_OFF:   hrdata <= {28'h0000000, rst_flags_q};
        FACTORY_TRIM_OFF: hrdata <= factory_word;
        default:          hrdata <= 32'h00000000;
      endcase
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      fast_rc_trim <= {RC_TRIM_RST, 2'h0};
    end else begin
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      fast_rc_trim <= {rc_trim_q, trim_low_q};
    end
  end

endmodule

// ==== verilog/clk_rst_pkg.sv ====
// Constants for the clock switch and reset sequencer block.
// Assumes a single 200 MHz bus clock and an AHB-Lite master with word accesses.
// Contract
// - Software writes ten-bit fast RC trim
// - Trim register resets to ff
// - Factory trim bytes read-only, fixed addresses
// - Factory low trim bits at 6:5
// - Comms mode forces fast RC clock
// - Select bit starts switch to slow RC
// - Three slow cycles, then switch
// - Fast RC stops after switch
// - Clearing select waits eight fast cycles
// - Flags update, switch, slow RC stops
// - Fast RC off when not selected
// - Slow RC on for wakeup/external clock
// - Startup clock from two option bits
// - Crystal keeps running during reset
// - Reset sources drive pin low during delay
// - Illegal opcode also causes reset
// - Vector fetch at fffe-ffff, two cycles
// - Delay 4096 or 256 by source
// - Low-voltage reset clears watchdog flag
package clk_rst_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] RC_TRIM_OFF      = 8'h00;
  localparam logic [7:0] SUPPLY_OFF       = 8'h04;
  localparam logic [7:0] CLK_CNT_OFF      = 8'h08;
  localparam logic [7:0] RESET_STAT_OFF   = 8'h0c;
  localparam logic [7:0] FACTORY_TRIM_OFF = 8'h10;

  // Field positions
  localparam int SUP_TRIM_LO = 5;
  localparam int SUP_TRIM_HI = 6;
  localparam int CK_SEL_BIT  = 0;
  localparam int CK_FAST_BIT = 1;
  localparam int CK_SLOW_BIT = 2;
  localparam int RS_WDG_BIT  = 0;
  localparam int RS_LVR_BIT  = 1;
  localparam int RS_ILL_BIT  = 2;
  localparam int RS_EXT_BIT  = 3;

  // Reset values
  localparam logic [7:0] RC_TRIM_RST = 8'hff;

  // Factory trim byte and reset vector addresses in nonvolatile space
  localparam logic [15:0] FACTORY_TRIM_BASE = 16'hdee0;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;

  // Startup clock option codes
  localparam logic [1:0] CKOPT_FAST_RC = 2'h0;
  localparam logic [1:0] CKOPT_SLOW_RC = 2'h1;
  localparam logic [1:0] CKOPT_EXT_CLK = 2'h2;
  localparam logic [1:0] CKOPT_XTAL    = 2'h3;

  // Switch timing in oscillator cycles
  localparam int SLOW_SETTLE_CYC = 3;
  localparam int FAST_SETTLE_CYC = 8;
  localparam int FAST_FLAG_CYC   = 2;

  // Reset delays in CPU cycles
  localparam int DELAY_LONG  = 4096;
  localparam int DELAY_SHORT = 256;
  localparam int FETCH_CYC   = 2;

  typedef enum logic [5:0] {
    SW_FAST      = 6'b000001,
    SW_TO_SLOW   = 6'b000010,
    SW_SLOW      = 6'b000100,
    SW_WAIT_FAST = 6'b001000,
    SW_FLAG_FAST = 6'b010000,
    SW_EXT       = 6'b100000
  } sw_state_t;

  typedef enum logic [2:0] {
    RS_ACTIVE = 3'b001,
    RS_DELAY  = 3'b010,
    RS_FETCH  = 3'b100
  } rs_state_t;

endpackage

// ==== bench/csr_chk.sv ====
// Port checker for the clock switch and reset sequencer.
// Assumes it is bound onto the top module and sees only its ports.
`timescale 1ns/1ps
module csr_chk
  import clk_rst_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [1:0]  startup_clock_option,
  input wire logic        in_circuit_comms,
  input wire logic        halt_wakeup_entry,
  input wire logic        ext_reset_in,
  input wire logic        low_voltage_reset,
  input wire logic        watchdog_reset,
  input wire logic        illegal_opcode,
  input wire logic        reset_pin_oe,
  input wire logic        cpu_reset_n,
  input wire logic        vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic [9:0]  fast_rc_trim,
  input wire logic        fast_rc_enable,
  input wire logic        slow_rc_enable,
  input wire logic        xtal_enable,
  input wire logic        sys_clk_sel_slow
);
  // One domain, so clock and reset are given once
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  pin_hold_a: assert property (!cpu_reset_n && !vector_fetch |-> reset_pin_oe)
    else $error("reset pin released in delay");
  src_pin_a: assert property (low_voltage_reset || watchdog_reset || !ext_reset_in
    |-> ##[0:4] reset_pin_oe) else $error("source did not drive pin");
  illegal_rst_a: assert property (illegal_opcode |-> ##[0:4] !cpu_reset_n)
    else $error("illegal opcode gave no reset");
  fetch_two_a: assert property ($rose(vector_fetch) |-> vector_addr == 16'hfffe
    ##1 vector_fetch && vector_addr == 16'hffff ##1 !vector_fetch)
    else $error("vector fetch shape wrong");
  trim_fetch_a: assert property (vector_fetch |-> fast_rc_trim[9:2] == RC_TRIM_RST)
    else $error("trim not back to default");
  fast_stop_a: assert property ($rose(sys_clk_sel_slow) |-> ##[0:4] !fast_rc_enable)
    else $error("fast RC kept running");
  slow_on_a: assert property (sys_clk_sel_slow |-> slow_rc_enable)
    else $error("slow clock selected but off");
  comms_fast_a: assert property (in_circuit_comms [*8] |-> !sys_clk_sel_slow)
    else $error("comms mode not on fast RC");
  ext_slow_a: assert property (cpu_reset_n && startup_clock_option == CKOPT_EXT_CLK
    |-> slow_rc_enable) else $error("slow RC off with ext clock");
  halt_slow_a: assert property (halt_wakeup_entry && !sys_clk_sel_slow
    |-> ##[0:2] slow_rc_enable) else $error("slow RC off at halt wakeup");
  xtal_run_a: assert property (!cpu_reset_n && startup_clock_option == CKOPT_XTAL
    |-> xtal_enable) else $error("crystal stopped in reset");
endmodule

bind clock_switch_reset_sequencer csr_chk u_chk (.*);

// ==== bench/osc_model.sv ====
// Oscillators and external reset circuit on the far side.
// Assumes enables come from the design and pulses from the bench.
`timescale 1ns/1ps
module osc_model (
  input  wire logic fast_rc_enable,
  input  wire logic slow_rc_enable,
  input  wire logic ext_req,
  output logic      fast_rc_clk,
  output logic      slow_rc_clk,
  output logic      ext_reset_in
);
  // fast RC runs only while enabled
  initial begin
    fast_rc_clk = 1'b0;
    // Slower than half the bus clock so the sampler sees every edge
    forever #11.3 fast_rc_clk = fast_rc_enable ? ~fast_rc_clk : 1'b0;
  end
  // slow RC stands still when disabled
  initial begin
    slow_rc_clk = 1'b0;
    forever #21.3 slow_rc_clk = slow_rc_enable ? ~slow_rc_clk : 1'b0;
  end
  // Pin pulled up unless the circuit pulls it low
  assign ext_reset_in = ~ext_req;
endmodule

// ==== bench/clock_switch_reset_sequencer_tb_top.sv ====
// Bench: register bus, clock switch and reset sequences with expected values.
// Assumes the oscillator model and the bound checker; short delays by parameter.
`timescale 1ns/1ps
module clock_switch_reset_sequencer_tb_top;
  import clk_rst_pkg::*;
  localparam int          LD = 32;
  localparam int          SD = 8;
  localparam logic [31:0] FT = 32'h20a5409c;  // Arbitrary factory bytes
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ext_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, startup_clock_option;
  logic [2:0]  hsize;
  logic        in_circuit_comms, halt_wakeup_entry, fast_rc_clk, slow_rc_clk;
  logic        ext_reset_in, low_voltage_reset, watchdog_reset, illegal_opcode;
  logic        reset_pin_out, reset_pin_oe, cpu_reset_n, vector_fetch, clock_gate_hold;
  logic        fast_rc_enable, slow_rc_enable, xtal_enable, sys_clk_sel_slow;
  logic [15:0] vector_addr;
  logic [9:0]  fast_rc_trim, t;
  int          fail_count = 0, num_checks = 0, n, e, sc = 0, fc = 0;

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

  // Clock, single slave so hready follows hreadyout
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  assign hready = hreadyout;
  always @(posedge slow_rc_clk) sc++;
  always @(posedge fast_rc_clk) fc++;

  clock_switch_reset_sequencer #(.LONG_DELAY(LD), .SHORT_DELAY(SD), .FT_HI0(FT[7:0]),
    .FT_LO0(FT[15:8]), .FT_HI1(FT[23:16]), .FT_LO1(FT[31:24])) u_dut (.*);
  osc_model u_osc (.fast_rc_enable(fast_rc_enable), .slow_rc_enable(slow_rc_enable),
    .ext_req(ext_req), .fast_rc_clk(fast_rc_clk), .slow_rc_clk(slow_rc_clk),
    .ext_reset_in(ext_reset_in));

  // One word transfer; address held until hready seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    `CHK(rd, x)
  endtask
  // Edges from source release to fetch, then wait for run
  task automatic run_to_fetch();
    n = 0;
    while (vector_fetch !== 1'b1) begin
      @(posedge hclk);
      n++;
    end
    `CHK(vector_addr, RESET_VECTOR_ADDR)
    `CHK({reset_pin_out, hresp}, 2'b00)
    while (cpu_reset_n !== 1'b1) @(posedge hclk);
    @(posedge hclk);
  endtask
  task automatic hard_reset(input logic [1:0] o, input logic c);
    hresetn <= 1'b0;
    // outside circuit holds the pin low until release
    ext_req <= 1'b1;
    startup_clock_option <= o;
    in_circuit_comms <= c;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    ext_req <= 1'b0;
    run_to_fetch();
  endtask
  // Short pulse on one source: 0 wdg, 1 low voltage, 2 illegal, 3 pin
  task automatic pulse(input int k);
    case (k)
      0: watchdog_reset <= 1'b1;
      1: low_voltage_reset <= 1'b1;
      2: illegal_opcode <= 1'b1;
      default: ext_req <= 1'b1;
    endcase
    repeat (4) @(posedge hclk);
    {ext_req, illegal_opcode, low_voltage_reset, watchdog_reset} <= 4'h0;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(25678));
    {hresetn, hsel, hwrite, ext_req, halt_wakeup_entry, in_circuit_comms} = 6'h0;
    {low_voltage_reset, watchdog_reset, illegal_opcode} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    startup_clock_option = 2'h0;
    @(posedge hclk);
    // Every option, then comms mode over a slow option
    for (int i = 0; i < 5; i++) begin
      hard_reset(i[1:0] | {1'b0, i == 4}, i == 4);
      e = (i == 1) ? SD : LD;
      `CHK(n >= e && n <= e + 8, 1'b1)
      `CHK(sys_clk_sel_slow, i == 1)
    end
    hard_reset(CKOPT_FAST_RC, 1'b0);
    rchk(RC_TRIM_OFF, 32'hff);
    repeat (4) begin
      t = 10'($urandom);
      bus(1'b1, RC_TRIM_OFF, {24'h0, t[9:2]});
      bus(1'b1, SUPPLY_OFF, {25'h0, t[1:0], 5'h0});
      rchk(RC_TRIM_OFF, {24'h0, t[9:2]});
      `CHK(fast_rc_trim, t)
    end
    rchk(FACTORY_TRIM_OFF, FT);
    bus(1'b1, FACTORY_TRIM_OFF, ~FT);
    rchk(FACTORY_TRIM_OFF, FT);
    rchk(8'h40, 32'h0);
    halt_wakeup_entry <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK(slow_rc_enable, 1'b1)
    halt_wakeup_entry <= 1'b0;
    repeat (8) @(posedge hclk);
    // Switch to slow RC and back, counting oscillator edges
    sc = 0;
    bus(1'b1, CLK_CNT_OFF, 32'h1);
    repeat (3) @(posedge hclk);
    `CHK(clock_gate_hold, 1'b1)
    while (sys_clk_sel_slow !== 1'b1) @(posedge hclk);
    `CHK(sc >= SLOW_SETTLE_CYC, 1'b1)
    repeat (8) @(posedge hclk);
    bus(1'b0, CLK_CNT_OFF, 32'h0);
    `CHK(rd[2:1], 2'b10)
    `CHK(fast_rc_enable, 1'b0)
    fc = 0;
    bus(1'b1, CLK_CNT_OFF, 32'h0);
    while (sys_clk_sel_slow !== 1'b0) @(posedge hclk);
    `CHK(fc >= FAST_SETTLE_CYC + FAST_FLAG_CYC, 1'b1)
    repeat (20) @(posedge hclk);
    bus(1'b0, CLK_CNT_OFF, 32'h0);
    `CHK(rd[2:1], 2'b01)
    `CHK(slow_rc_enable, 1'b0)
    // Each source resets, sets its flag and restores the trim
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, RESET_STAT_OFF, 32'hf);
      bus(1'b1, RC_TRIM_OFF, 32'h0);
      pulse(k);
      run_to_fetch();
      `CHK(n >= LD && n <= LD + 8, 1'b1)
      rchk(RESET_STAT_OFF, 32'h1 << k);
      rchk(RC_TRIM_OFF, 32'hff);
    end
    // Low voltage arrives in the delay of a watchdog reset
    bus(1'b1, RESET_STAT_OFF, 32'hf);
    pulse(0);
    repeat (10) @(posedge hclk);
    pulse(1);
    run_to_fetch();
    `CHK(n >= LD && n <= LD + 8, 1'b1)
    rchk(RESET_STAT_OFF, 32'h2);
    end_sim();
  end

  // Hang guard well beyond the expected run
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    end_sim();
  end
endmodule
